// ==== verilog/acq_shared_memory_arbiter.sv ====
// acquisition shared-memory arbiter, remote port, strobe and head control
`timescale 1ns/1ns
module acq_shared_memory_arbiter #(
	parameter int HEADS = acq_arb_pkg::HEADS,
	parameter int DW = acq_arb_pkg::DATA_W,
	parameter int FIFO_DEPTH = acq_arb_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// time-base strobe and local self-test control
	input wire logic tb_strobe_i,
	input wire logic local_strobe_en_i,
	input wire logic [acq_arb_pkg::STROBE_DIV_W-1:0] local_strobe_div_i,
	output logic head_strobe_o,
	output logic adc_convert_o,
	output logic meas_clock_o,
	// a/d sample path
	input wire logic [DW-1:0] adc_data_i,
	input wire logic adc_start_i,
	output logic adc_overrun_o,
	// local processor bus
	input wire logic loc_req_i,
	input wire logic loc_we_i,
	input wire logic [acq_arb_pkg::LOCAL_AW-1:0] loc_addr_i,
	input wire logic [DW-1:0] loc_wdata_i,
	output logic [DW-1:0] loc_rdata_o,
	output logic loc_ack_o,
	output logic [acq_arb_pkg::LOCAL_AW-1:0] rom_addr_o,
	input wire logic [DW-1:0] rom_data_i,
	input wire logic loc_rom_sel_i,
	// remote time-base processor port
	input wire logic rem_req_i,
	input wire logic rem_we_i,
	input wire logic [acq_arb_pkg::SHARED_AW-1:0] rem_addr_i,
	input wire logic [DW-1:0] rem_wdata_i,
	output logic [DW-1:0] rem_rdata_o,
	output logic rem_wait_o,
	// head control
	input wire logic [HEADS-1:0] head_button_i,
	output logic [HEADS-1:0] head_button_o,
	input wire logic [HEADS-1:0] head_lamp_i,
	output logic [HEADS-1:0] head_lamp_o,
	input wire logic [2*HEADS-1:0] reflect_step_enable_i,
	input wire logic [HEADS-1:0] smooth_enable_i,
	output logic [2*HEADS-1:0] reflect_step_enable_o,
	output logic [HEADS-1:0] smooth_enable_o
);
	typedef enum logic [1:0] {
		ARB_IDLE = 2'b00,
		ARB_ACCESS = 2'b01,
		ARB_DONE = 2'b10
	} arb_state_e;
	localparam int SAW = acq_arb_pkg::SHARED_AW;
	localparam int FW = SAW + DW;

	function automatic logic [1:0] loc_decode(input logic [acq_arb_pkg::LOCAL_AW-1:0] a);
		logic [1:0] sel;
		sel = acq_arb_pkg::LOC_SEL_NONE;
		if (a[15:14] == acq_arb_pkg::LOC_SHARED_BASE[15:14]) begin
			sel = acq_arb_pkg::LOC_SEL_SHARED;
		end else if (a[15:13] == acq_arb_pkg::LOC_LRAM_BASE[15:13]) begin
			sel = acq_arb_pkg::LOC_SEL_LRAM;
		end
		return sel;
	endfunction

	logic [DW-1:0] shared_mem [acq_arb_pkg::SHARED_BYTES];
	logic [DW-1:0] local_ram [acq_arb_pkg::LOCAL_RAM_BYTES];
	arb_state_e state_r;
	logic [1:0] owner_r;
	logic strobe_pulse;
	logic [7:0] cap_dly_r;
	logic [SAW-1:0] adc_wr_ptr_r;
	logic fifo_in_valid_r;
	logic [FW-1:0] fifo_in_data_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FW-1:0] fifo_out_data;
	logic rem_lat_valid_r;
	logic rem_lat_we_r;
	logic [SAW-1:0] rem_lat_addr_r;
	logic [DW-1:0] rem_lat_wdata_r;
	logic [DW-1:0] rem_rdata_r;
	logic rem_done_r;
	logic [DW-1:0] loc_rdata_r;
	logic loc_ack_r;
	logic loc_shared;
	logic loc_lram;
	logic [1:0] grant_nxt;
	logic [SAW-1:0] mem_addr;
	logic [DW-1:0] mem_wdata;
	logic mem_we;
	logic [HEADS-1:0] btn_meta_r;
	logic [HEADS-1:0] btn_sync_r;

	acq_strobe_gen #(
		.DIV_W(acq_arb_pkg::STROBE_DIV_W)
	) u_strobe (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.tb_strobe_i(tb_strobe_i),
		.local_strobe_en_i(local_strobe_en_i),
		.local_strobe_div_i(local_strobe_div_i),
		.strobe_pulse_o(strobe_pulse),
		.head_strobe_o(head_strobe_o)
	);

	acq_sample_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.in_valid_i(fifo_in_valid_r),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_in_data_r),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	// digitize and measurement timing from the strobe
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			cap_dly_r <= 8'h00;
			adc_convert_o <= 1'b0;
			meas_clock_o <= 1'b0;
		end else begin
			cap_dly_r <= {cap_dly_r[6:0], strobe_pulse};
			adc_convert_o <= strobe_pulse;
			meas_clock_o <= |(cap_dly_r & acq_arb_pkg::SMP_CAPTURE_DELAY);
		end
	end

	// sample capture into fifo, address rewinds on acquisition start
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			fifo_in_valid_r <= 1'b0;
			fifo_in_data_r <= '0;
			adc_wr_ptr_r <= '0;
			adc_overrun_o <= 1'b0;
		end else begin
			// staged sample held until the fifo takes it
			if (fifo_in_ready) begin
				fifo_in_valid_r <= 1'b0;
			end
			if (adc_start_i) begin
				adc_wr_ptr_r <= '0;
			end else if (meas_clock_o && (fifo_in_ready || !fifo_in_valid_r)) begin
				fifo_in_valid_r <= 1'b1;
				fifo_in_data_r <= {adc_wr_ptr_r, adc_data_i};
				adc_wr_ptr_r <= adc_wr_ptr_r + 1'b1;
			end
			// a drop beside a restart still flags
			if (meas_clock_o && fifo_in_valid_r && !fifo_in_ready) begin
				adc_overrun_o <= 1'b1;
			end else if (adc_start_i) begin
				adc_overrun_o <= 1'b0;
			end
		end
	end

	assign loc_shared = loc_req_i && !loc_rom_sel_i && (loc_decode(loc_addr_i) == acq_arb_pkg::LOC_SEL_SHARED);
	assign loc_lram = loc_req_i && !loc_rom_sel_i && (loc_decode(loc_addr_i) == acq_arb_pkg::LOC_SEL_LRAM);

	// remote address decode and latch
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rem_lat_valid_r <= 1'b0;
			rem_lat_we_r <= 1'b0;
			rem_lat_addr_r <= '0;
			rem_lat_wdata_r <= '0;
		end else if (rem_done_r) begin
			rem_lat_valid_r <= 1'b0;
		end else if (rem_req_i && !rem_lat_valid_r) begin
			rem_lat_valid_r <= 1'b1;
			rem_lat_we_r <= rem_we_i;
			rem_lat_addr_r <= rem_addr_i;
			rem_lat_wdata_r <= rem_wdata_i;
		end
	end

	// fixed priority: a/d, then local, then remote
	always_comb begin
		grant_nxt = acq_arb_pkg::REQ_IDLE;
		if (fifo_out_valid) begin
			grant_nxt = acq_arb_pkg::REQ_ADC;
		end else if (loc_shared && !loc_ack_r) begin
			grant_nxt = acq_arb_pkg::REQ_LOCAL;
		end else if (rem_lat_valid_r && !rem_done_r) begin
			grant_nxt = acq_arb_pkg::REQ_REMOTE;
		end
	end

	// one owner per memory cycle
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= ARB_IDLE;
			owner_r <= acq_arb_pkg::REQ_IDLE;
		end else begin
			case (state_r)
				ARB_IDLE: begin
					if (grant_nxt != acq_arb_pkg::REQ_IDLE) begin
						state_r <= ARB_ACCESS;
						owner_r <= grant_nxt;
					end
				end
				ARB_ACCESS: begin
					state_r <= ARB_DONE;
				end
				ARB_DONE: begin
					state_r <= ARB_IDLE;
					owner_r <= acq_arb_pkg::REQ_IDLE;
				end
				default: begin
					state_r <= ARB_IDLE;
					owner_r <= acq_arb_pkg::REQ_IDLE;
				end
			endcase
		end
	end

	assign fifo_out_ready = (state_r == ARB_ACCESS) && (owner_r == acq_arb_pkg::REQ_ADC);

	always_comb begin
		mem_addr = '0;
		mem_wdata = '0;
		mem_we = 1'b0;
		if (state_r == ARB_ACCESS) begin
			case (owner_r)
				acq_arb_pkg::REQ_ADC: begin
					mem_addr = fifo_out_data[FW-1:DW];
					mem_wdata = fifo_out_data[DW-1:0];
					mem_we = 1'b1;
				end
				acq_arb_pkg::REQ_LOCAL: begin
					mem_addr = loc_addr_i[SAW-1:0];
					mem_wdata = loc_wdata_i;
					mem_we = loc_we_i;
				end
				acq_arb_pkg::REQ_REMOTE: begin
					mem_addr = rem_lat_addr_r;
					mem_wdata = rem_lat_wdata_r;
					mem_we = rem_lat_we_r;
				end
				default: begin
					mem_we = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (mem_we) begin
			shared_mem[mem_addr] <= mem_wdata;
		end
	end

	// remote read data and completion
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rem_rdata_r <= '0;
			rem_done_r <= 1'b0;
		end else begin
			rem_done_r <= (state_r == ARB_ACCESS) && (owner_r == acq_arb_pkg::REQ_REMOTE);
			if ((state_r == ARB_ACCESS) && (owner_r == acq_arb_pkg::REQ_REMOTE) && !rem_lat_we_r) begin
				rem_rdata_r <= shared_mem[mem_addr];
			end
		end
	end

	assign rem_rdata_o = rem_rdata_r;
	assign rem_wait_o = (rem_req_i || rem_lat_valid_r) && !rem_done_r;

	// local bus: shared ram via arbiter, private ram and rom direct
	always_ff @(posedge clk_sys_i) begin
		if (loc_lram && loc_we_i) begin
			local_ram[loc_addr_i[12:0]] <= loc_wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			loc_rdata_r <= '0;
			loc_ack_r <= 1'b0;
		end else begin
			loc_ack_r <= 1'b0;
			if (loc_ack_r) begin
				loc_ack_r <= 1'b0;
			end else if (loc_req_i && loc_rom_sel_i) begin
				loc_rdata_r <= rom_data_i;
				loc_ack_r <= 1'b1;
			end else if (loc_lram) begin
				loc_rdata_r <= local_ram[loc_addr_i[12:0]];
				loc_ack_r <= 1'b1;
			end else if ((state_r == ARB_ACCESS) && (owner_r == acq_arb_pkg::REQ_LOCAL)) begin
				loc_rdata_r <= shared_mem[mem_addr];
				loc_ack_r <= 1'b1;
			end else if (loc_req_i && !loc_rom_sel_i && (loc_decode(loc_addr_i) == acq_arb_pkg::LOC_SEL_NONE)) begin
				loc_rdata_r <= '0;
				loc_ack_r <= 1'b1;
			end
		end
	end

	assign loc_rdata_o = loc_rdata_r;
	assign loc_ack_o = loc_ack_r;
	assign rom_addr_o = loc_addr_i;

	// head buttons synchronised for the local processor, lamps registered out
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			btn_meta_r <= '0;
			btn_sync_r <= '0;
			head_lamp_o <= '0;
			reflect_step_enable_o <= '0;
			smooth_enable_o <= '0;
		end else begin
			btn_meta_r <= head_button_i;
			btn_sync_r <= btn_meta_r;
			head_lamp_o <= head_lamp_i;
			reflect_step_enable_o <= reflect_step_enable_i;
			smooth_enable_o <= smooth_enable_i;
		end
	end

	assign head_button_o = btn_sync_r;
endmodule

// ==== inc/acq_arb_pkg.sv ====
// shared constants for the acquisition shared-memory arbiter
package acq_arb_pkg;
	localparam int SHARED_BYTES = 16384;
	localparam int SHARED_AW = 14;
	localparam int CODE_ROM_BYTES = 65536;
	localparam int LOCAL_RAM_BYTES = 8192;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int LOCAL_AW = 16;
	// local processor map: code rom 0x0000-0xFFFF in its own space, ram windows below
	localparam logic [LOCAL_AW-1:0] LOC_LRAM_BASE = 16'h0000;
	localparam logic [LOCAL_AW-1:0] LOC_SHARED_BASE = 16'h4000;
	localparam logic [1:0] LOC_SEL_LRAM = 2'h0;
	localparam logic [1:0] LOC_SEL_SHARED = 2'h1;
	localparam logic [1:0] LOC_SEL_NONE = 2'h2;
	localparam logic [1:0] REQ_ADC = 2'h0;
	localparam logic [1:0] REQ_LOCAL = 2'h1;
	localparam logic [1:0] REQ_REMOTE = 2'h2;
	localparam logic [1:0] REQ_IDLE = 2'h3;
	localparam int HEADS = 4;
	localparam int STROBE_DIV_W = 16;
	localparam logic [STROBE_DIV_W-1:0] STROBE_DIV_RST = 16'h0031;
	localparam logic [7:0] SMP_CAPTURE_DELAY = 8'h02;
endpackage

// ==== verilog/acq_sample_fifo.sv ====
// sample fifo between the a/d path and the shared-memory arbiter
`timescale 1ns/1ns
module acq_sample_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_ptr_r;
	logic [PW:0] rd_ptr_r;
	logic full;
	logic empty;
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full = (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]) && (wr_ptr_r[PW] != rd_ptr_r[PW]);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr_r[PW-1:0]];
	always_ff @(posedge clk_sys_i) begin
		if (in_valid_i && !full) begin
			mem[wr_ptr_r[PW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr_r <= '0;
		end else if (in_valid_i && !full) begin
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rd_ptr_r <= '0;
		end else if (out_ready_i && !empty) begin
			rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule

// ==== verilog/acq_strobe_gen.sv ====
// strobe select: time-base strobe or local self-test strobe, with edge detect
`timescale 1ns/1ns
module acq_strobe_gen #(
	parameter int DIV_W = 16
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic tb_strobe_i,
	input wire logic local_strobe_en_i,
	input wire logic [DIV_W-1:0] local_strobe_div_i,
	output logic strobe_pulse_o,
	output logic head_strobe_o
);
	logic tb_meta_r;
	logic tb_sync_r;
	logic tb_prev_r;
	logic [DIV_W-1:0] div_cnt_r;
	logic local_pulse_r;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tb_meta_r <= 1'b0;
			tb_sync_r <= 1'b0;
			tb_prev_r <= 1'b0;
		end else begin
			tb_meta_r <= tb_strobe_i;
			tb_sync_r <= tb_meta_r;
			tb_prev_r <= tb_sync_r;
		end
	end
	// local strobe generator for self-test
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			div_cnt_r <= '0;
			local_pulse_r <= 1'b0;
		end else if (!local_strobe_en_i) begin
			div_cnt_r <= '0;
			local_pulse_r <= 1'b0;
		end else if (div_cnt_r >= local_strobe_div_i) begin
			div_cnt_r <= '0;
			local_pulse_r <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 1'b1;
			local_pulse_r <= 1'b0;
		end
	end
	assign strobe_pulse_o = local_strobe_en_i ? local_pulse_r : (tb_sync_r && !tb_prev_r);
	assign head_strobe_o = local_strobe_en_i ? local_pulse_r : 1'b0;
endmodule

// ==== verification/acq_arbiter_sva.sv ====
// assertion checker for the shared-memory arbiter ports
`timescale 1ns/1ns
module acq_arbiter_sva #(
	parameter int HEADS = 4,
	parameter int DW = 8
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic tb_strobe_i,
	input wire logic local_strobe_en_i,
	input wire logic head_strobe_o,
	input wire logic adc_convert_o,
	input wire logic meas_clock_o,
	input wire logic adc_start_i,
	input wire logic adc_overrun_o,
	input wire logic loc_req_i,
	input wire logic [acq_arb_pkg::LOCAL_AW-1:0] loc_addr_i,
	input wire logic loc_rom_sel_i,
	input wire logic loc_ack_o,
	input wire logic rem_req_i,
	input wire logic rem_we_i,
	input wire logic [DW-1:0] rem_rdata_o,
	input wire logic rem_wait_o,
	input wire logic [HEADS-1:0] head_lamp_i,
	input wire logic [HEADS-1:0] head_lamp_o,
	input wire logic [2*HEADS-1:0] reflect_step_enable_i,
	input wire logic [2*HEADS-1:0] reflect_step_enable_o,
	input wire logic [HEADS-1:0] smooth_enable_i,
	input wire logic [HEADS-1:0] smooth_enable_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	sequence strobe_pair;
		adc_convert_o ##2 meas_clock_o;
	endsequence
	sequence rem_stall;
		rem_wait_o [*3];
	endsequence
	wait_hold_a: assert property ($rose(rem_req_i) |-> rem_stall)
		else $error("remote wait released too early");
	wait_bound_a: assert property (rem_req_i && rem_wait_o |-> ##[1:60] !rem_wait_o)
		else $error("remote wait never released");
	rdata_hold_a: assert property ($changed(rem_rdata_o) |-> rem_req_i && !rem_wait_o && !rem_we_i)
		else $error("remote read data changed outside a read completion");
	strobe_timing_a: assert property (adc_convert_o |-> strobe_pair)
		else $error("measurement clock not two cycles after convert");
	tb_strobe_a: assert property ($rose(tb_strobe_i) && !local_strobe_en_i |-> ##[1:5] adc_convert_o)
		else $error("time-base strobe gave no conversion");
	head_mode_a: assert property (head_strobe_o |-> local_strobe_en_i ##1 adc_convert_o)
		else $error("head strobe outside local mode or without conversion");
	head_lines_a: assert property (!$past(reset_i) |-> {reflect_step_enable_o, smooth_enable_o, head_lamp_o}
		== $past({reflect_step_enable_i, smooth_enable_i, head_lamp_i}))
		else $error("head control lines not passed on");
	private_ack_a: assert property ($rose(loc_req_i) && !loc_rom_sel_i && loc_addr_i[15:13] == 3'h0
		|=> loc_ack_o)
		else $error("private ram access not answered in one cycle");
	local_bound_a: assert property ($rose(loc_req_i) |-> ##[1:20] loc_ack_o)
		else $error("local access never granted");
	ack_pulse_a: assert property (loc_ack_o |=> !loc_ack_o)
		else $error("local ack longer than one cycle");
	overrun_sticky_a: assert property (adc_overrun_o && !adc_start_i |=> adc_overrun_o)
		else $error("overrun flag dropped without restart");
endmodule
bind acq_shared_memory_arbiter acq_arbiter_sva #(.HEADS(HEADS), .DW(DW)) chk_u (.clk_sys_i, .reset_i,
	.tb_strobe_i, .local_strobe_en_i, .head_strobe_o, .adc_convert_o, .meas_clock_o, .adc_start_i,
	.adc_overrun_o, .loc_req_i, .loc_addr_i, .loc_rom_sel_i, .loc_ack_o, .rem_req_i, .rem_we_i,
	.rem_rdata_o, .rem_wait_o, .head_lamp_i, .head_lamp_o, .reflect_step_enable_i,
	.reflect_step_enable_o, .smooth_enable_i, .smooth_enable_o);

// ==== verification/remote_proc_model.sv ====
// model of the remote time-base processor on the shared-memory port
`timescale 1ns/1ns
module remote_proc_model (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic go_i,
	input wire logic we_i,
	input wire logic [acq_arb_pkg::SHARED_AW-1:0] addr_i,
	input wire logic [acq_arb_pkg::DATA_W-1:0] wdata_i,
	input wire logic rem_wait_i,
	input wire logic [acq_arb_pkg::DATA_W-1:0] rem_rdata_i,
	output logic rem_req_o,
	output logic rem_we_o,
	output logic [acq_arb_pkg::SHARED_AW-1:0] rem_addr_o,
	output logic [acq_arb_pkg::DATA_W-1:0] rem_wdata_o,
	output logic done_o,
	output logic [acq_arb_pkg::DATA_W-1:0] rdata_o
);
	logic hit_r = 1'b0;
	// completion taken at the edge where wait is seen low
	always @(posedge clk_sys_i) begin
		hit_r <= rem_req_o && !rem_wait_i;
		if (rem_req_o && !rem_wait_i) begin
			rdata_o <= rem_rdata_i;
		end
	end
	// request held while stalled, lines scrambled once released
	always @(negedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rem_req_o <= 1'b0;
			rem_we_o <= 1'b0;
			rem_addr_o <= '0;
			rem_wdata_o <= '0;
			done_o <= 1'b0;
		end else if (rem_req_o && hit_r) begin
			rem_req_o <= 1'b0;
			rem_we_o <= ~rem_we_o;
			rem_addr_o <= ~rem_addr_o;
			rem_wdata_o <= ~rem_wdata_o;
			done_o <= 1'b1;
		end else if (go_i && !rem_req_o) begin
			rem_req_o <= 1'b1;
			rem_we_o <= we_i;
			rem_addr_o <= addr_i;
			rem_wdata_o <= wdata_i;
			done_o <= 1'b0;
		end
	end
endmodule

// ==== verification/test_acq_shared_memory_arbiter.sv ====
// self-checking bench for the shared-memory arbiter
`timescale 1ns/1ns
module test_acq_shared_memory_arbiter;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, tb_strobe_i = 1'b0, local_strobe_en_i = 1'b0, adc_start_i = 1'b0;
	logic [15:0] local_strobe_div_i = 16'h0000, loc_addr_i = 16'h0000, rom_addr_o;
	logic [7:0] adc_data_i = 8'h00, loc_wdata_i = 8'h00, rom_data_i, loc_rdata_o, rem_rdata_o, q, q2;
	logic loc_req_i = 1'b0, loc_we_i = 1'b0, loc_rom_sel_i = 1'b0, loc_ack_o, rem_req_i, rem_we_i, rem_wait_o;
	logic head_strobe_o, adc_convert_o, meas_clock_o, adc_overrun_o, go = 1'b0, p_we = 1'b0, p_done;
	logic [13:0] rem_addr_i, p_addr = 14'h0000;
	logic [7:0] rem_wdata_i, p_wdata = 8'h00, p_rdata;
	logic [3:0] head_button_i = 4'h0, head_button_o, head_lamp_i = 4'h0, head_lamp_o;
	logic [3:0] smooth_enable_i = 4'h0, smooth_enable_o;
	logic [7:0] reflect_step_enable_i = 8'h00, reflect_step_enable_o;
	logic [15:0] rows [5] = '{16'h0000, 16'hFFFF, 16'hA5C3, 16'h5A3C, 16'h8001};
	int miscompares = 0, n_checks = 0, cycles = 0, n_conv = 0, n_meas = 0, n_head = 0, s_conv, s_meas, s_head;
	assign rom_data_i = rom_addr_o[7:0] ^ 8'h5A;
	acq_shared_memory_arbiter #(.HEADS(4), .DW(8), .FIFO_DEPTH(16)) dut_u (.clk_sys_i, .reset_i, .tb_strobe_i,
		.local_strobe_en_i, .local_strobe_div_i, .head_strobe_o, .adc_convert_o, .meas_clock_o, .adc_data_i,
		.adc_start_i, .adc_overrun_o, .loc_req_i, .loc_we_i, .loc_addr_i, .loc_wdata_i, .loc_rdata_o,
		.loc_ack_o, .rom_addr_o, .rom_data_i, .loc_rom_sel_i, .rem_req_i, .rem_we_i, .rem_addr_i,
		.rem_wdata_i, .rem_rdata_o, .rem_wait_o, .head_button_i, .head_button_o, .head_lamp_i,
		.head_lamp_o, .reflect_step_enable_i, .smooth_enable_i, .reflect_step_enable_o, .smooth_enable_o);
	remote_proc_model partner_u (.clk_sys_i, .reset_i, .go_i(go), .we_i(p_we), .addr_i(p_addr),
		.wdata_i(p_wdata), .rem_wait_i(rem_wait_o), .rem_rdata_i(rem_rdata_o), .rem_req_o(rem_req_i),
		.rem_we_o(rem_we_i), .rem_addr_o(rem_addr_i), .rem_wdata_o(rem_wdata_i), .done_o(p_done),
		.rdata_o(p_rdata));
	always #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		n_conv += (adc_convert_o === 1'b1);
		n_meas += (meas_clock_o === 1'b1);
		n_head += (head_strobe_o === 1'b1);
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic loc_op(input logic rom, we, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r);
		int k;
		@(negedge clk_sys_i);
		{loc_rom_sel_i, loc_we_i, loc_addr_i, loc_wdata_i, loc_req_i} = {rom, we, a, d, 1'b1};
		k = 0;
		do begin
			@(posedge clk_sys_i);
			#1 k++;
		end while (loc_ack_o !== 1'b1 && k < 40);
		r = loc_rdata_o;
		@(negedge clk_sys_i);
		loc_req_i = 1'b0;
	endtask
	task automatic rem_op(input logic we, input logic [13:0] a, input logic [7:0] d, output logic [7:0] r);
		int k;
		@(negedge clk_sys_i);
		{p_we, p_addr, p_wdata, go} <= {we, a, d, 1'b1};
		@(negedge clk_sys_i);
		go <= 1'b0;
		k = 0;
		do begin
			@(negedge clk_sys_i);
			k++;
		end while (p_done !== 1'b1 && k < 80);
		r = p_rdata;
	endtask
	task automatic tb_sample(input logic [7:0] d);
		@(negedge clk_sys_i);
		adc_data_i = d;
		tb_strobe_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		tb_strobe_i = 1'b0;
		repeat (15) @(negedge clk_sys_i);
	endtask
	initial begin
		repeat (19) @(negedge clk_sys_i);
		check({adc_overrun_o, loc_ack_o, adc_convert_o, meas_clock_o, rem_wait_o, rem_rdata_o}, 16'h0000);
		@(negedge clk_sys_i);
		reset_i = 1'b0;
		// outputs mirror the inputs row by row
		foreach (rows[i]) begin
			@(negedge clk_sys_i);
			{reflect_step_enable_i, smooth_enable_i, head_lamp_i} = rows[i];
			head_button_i = rows[i][3:0];
			repeat (3) @(negedge clk_sys_i);
			check({reflect_step_enable_o, smooth_enable_o, head_lamp_o}, rows[i]);
			check(head_button_o, rows[i][3:0]);
		end
		rem_op(1'b1, 14'h3FFF, 8'hA7, q);
		loc_op(1'b0, 1'b0, 16'h7FFF, 8'h00, q);
		check(q, 8'hA7);
		loc_op(1'b0, 1'b1, 16'h4000, 8'h5E, q);
		rem_op(1'b0, 14'h0000, 8'h00, q);
		check(q, 8'h5E);
		loc_op(1'b0, 1'b1, 16'h4000, 8'h11, q);
		check(rem_rdata_o, 8'h5E);
		loc_op(1'b0, 1'b1, 16'h1FFF, 8'h99, q);
		loc_op(1'b0, 1'b0, 16'h1FFF, 8'h00, q);
		check(q, 8'h99);
		loc_op(1'b0, 1'b0, 16'h2000, 8'h00, q);
		check(q, 8'h00);
		loc_op(1'b1, 1'b0, 16'hFFFF, 8'h00, q);
		check(q, 8'hA5);
		fork
			rem_op(1'b0, 14'h3FFF, 8'h00, q);
			loc_op(1'b0, 1'b0, 16'h7FFF, 8'h00, q2);
		join
		check({q, q2}, 16'hA7A7);
		local_strobe_div_i = 16'h0004;
		local_strobe_en_i = 1'b1;
		repeat (10) @(negedge clk_sys_i);
		{s_conv, s_head} = {n_conv, n_head};
		repeat (50) @(negedge clk_sys_i);
		check(16'(n_head - s_head), 16'h000A);
		check(16'(n_conv - s_conv), 16'h000A);
		local_strobe_div_i = 16'h0000;
		repeat (60) @(negedge clk_sys_i);
		check(adc_overrun_o, 1'b1);
		local_strobe_en_i = 1'b0;
		repeat (80) @(negedge clk_sys_i);
		adc_start_i = 1'b1;
		@(negedge clk_sys_i);
		adc_start_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		check(adc_overrun_o, 1'b0);
		{s_conv, s_meas, s_head} = {n_conv, n_meas, n_head};
		tb_sample(8'h3C);
		check(16'(n_conv - s_conv), 16'h0001);
		check(16'(n_meas - s_meas), 16'h0001);
		check(16'(n_head - s_head), 16'h0000);
		tb_sample(8'hC3);
		rem_op(1'b0, 14'h0000, 8'h00, q);
		check(q, 8'h3C);
		rem_op(1'b0, 14'h0001, 8'h00, q);
		check(q, 8'hC3);
		// reset in mid-run clears the outputs, lines pass again after it
		@(negedge clk_sys_i);
		reset_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		check({adc_overrun_o, loc_ack_o, adc_convert_o, meas_clock_o, rem_wait_o, rem_rdata_o}, 16'h0000);
		check({reflect_step_enable_o, smooth_enable_o, head_lamp_o}, 16'h0000);
		reset_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		check({reflect_step_enable_o, smooth_enable_o, head_lamp_o}, rows[4]);
		conclude();
	end
endmodule
